// *** logic/sfi_fault_ind.sv ***
`default_nettype none
module sfi_fault_ind #(
	parameter int unsigned PERIOD_CYC = sfi_pkg::PERIOD_CYC,
	parameter int unsigned BLINK_CYC  = sfi_pkg::BLINK_CYC,
	parameter int unsigned BIT_CYC    = sfi_pkg::BIT_CYC
) (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	input  wire logic ovolt_det_i,
	input  wire logic phase_err_i,
	input  wire logic ocur_det_i,
	input  wire logic rxd_i,
	output var  logic txd_o,
	output var  logic drive_en_o,
	output var  logic ready_o,
	output var  logic red_led_o,
	output var  logic green_led_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic              oc;
		logic              ov;
		logic              ph;
		logic              up;
		logic [31:0]       pcnt;
		logic [31:0]       bcnt;
		logic [3:0]        slot;
		logic              red;
		logic              green;
		logic              drv;
		logic              rdy;
		logic              txd;
		logic [7:0]        tdat;
		logic              tstb;
	} sfi_st_t;
	sfi_st_t s_r, s_nxt;

	logic [7:0] rx_data;
	logic       rx_stb;
	logic       u_txd;
	logic       tx_busy;
	logic [2:0] blinks;
	logic       any_f;

	sfi_uart #(.BIT_CYC(BIT_CYC)) u_uart (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.rxd_i     (rxd_i),
		.rx_data_o (rx_data),
		.rx_stb_o  (rx_stb),
		.tx_data_i (s_r.tdat),
		.tx_stb_i  (s_r.tstb),
		.txd_o     (u_txd),
		.tx_busy_o (tx_busy)
	);

	// Displayed fault by priority
	always_comb
	begin
		if (s_r.oc)
			blinks = sfi_pkg::BLINKS_OC;
		else if (s_r.ov)
			blinks = sfi_pkg::BLINKS_OV;
		else if (s_r.ph)
			blinks = sfi_pkg::BLINKS_PH;
		else
			blinks = 3'h0;
	end
	assign any_f = s_r.oc | s_r.ov | s_r.ph;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tstb = 1'b0;
		// Sticky latches; only reset, i.e. power cycling, clears them
		s_nxt.oc = s_r.oc | ocur_det_i;
		s_nxt.ov = s_r.ov | ovolt_det_i;
		s_nxt.ph = s_r.ph | phase_err_i;
		s_nxt.up = 1'b1;
		s_nxt.green = 1'b1;
		// Defaults are built in, so drive comes up without host
		s_nxt.drv = s_r.up & ~any_f;
		s_nxt.rdy = s_r.up & ~any_f;
		// Period and blink timers run freely from release
		if (s_r.pcnt == 32'(PERIOD_CYC - 1))
		begin
			s_nxt.pcnt = 32'h0;
			s_nxt.bcnt = 32'h0;
			s_nxt.slot = 4'h0;
		end
		else
		begin
			s_nxt.pcnt = s_r.pcnt + 32'h1;
			if (s_r.bcnt == 32'(BLINK_CYC - 1))
			begin
				s_nxt.bcnt = 32'h0;
				if (s_r.slot != 4'hf)
					s_nxt.slot = s_r.slot + 4'h1;
			end
			else
				s_nxt.bcnt = s_r.bcnt + 32'h1;
		end
		// Even slots on, odd off, until blink count used up
		s_nxt.red = any_f & ~s_nxt.slot[0]
			& (s_nxt.slot[3:1] < blinks);
		// Status query answer; a query while busy is dropped
		if (rx_stb && rx_data == sfi_pkg::CMD_STATUS && !tx_busy)
		begin
			s_nxt.tdat = sfi_pkg::ANS_BASE | {5'h0, s_r.ph, s_r.ov, s_r.oc};
			s_nxt.tstb = 1'b1;
		end
		s_nxt.txd = u_txd;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_r <= '0;
			s_r.txd <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign txd_o = s_r.txd;
	assign drive_en_o = s_r.drv;
	assign ready_o = s_r.rdy;
	assign red_led_o = s_r.red;
	assign green_led_o = s_r.green;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_fault_in;
		ovolt_det_i || phase_err_i || ocur_det_i;
	endsequence
	property p_latch;
		@(posedge mclk_i) disable iff (sys_rst_i) s_fault_in |=> ##1 !drive_en_o;
	endproperty
	a_latch: assert property (p_latch) else $error("fault did not stop drive");
	property p_sticky;
		@(posedge mclk_i) disable iff (sys_rst_i) !drive_en_o && s_r.up && any_f |=> !drive_en_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault cleared");
	property p_ov;
		@(posedge mclk_i) disable iff (sys_rst_i) $rose(s_r.ov) |=> s_r.ov;
	endproperty
	a_ov: assert property (p_ov) else $error("ov not held");
	property p_ph;
		@(posedge mclk_i) disable iff (sys_rst_i) phase_err_i |=> s_r.ph;
	endproperty
	a_ph: assert property (p_ph) else $error("phase not latched");
	property p_green;
		@(posedge mclk_i) disable iff (sys_rst_i) s_r.up |-> green_led_o;
	endproperty
	a_green: assert property (p_green) else $error("green off");
	property p_ready;
		@(posedge mclk_i) disable iff (sys_rst_i) ready_o |-> drive_en_o && !red_led_o && !$past(any_f);
	endproperty
	a_ready: assert property (p_ready) else $error("ready during fault");
	property p_boot;
		@(posedge mclk_i) disable iff (sys_rst_i)
			s_r.up && !any_f && !(ovolt_det_i || phase_err_i || ocur_det_i) |=> drive_en_o;
	endproperty
	a_boot: assert property (p_boot) else $error("drive not enabled");
	property p_prio;
		@(posedge mclk_i) disable iff (sys_rst_i) $past(s_r.oc) |-> red_led_o == (s_r.slot == 4'h0);
	endproperty
	a_prio: assert property (p_prio) else $error("priority wrong");
	property p_ovb;
		@(posedge mclk_i) disable iff (sys_rst_i)
			$past(s_r.ov && !s_r.oc) |-> red_led_o == (s_r.slot == 4'h0 || s_r.slot == 4'h2);
	endproperty
	a_ovb: assert property (p_ovb) else $error("ov blinks wrong");
	property p_phb;
		@(posedge mclk_i) disable iff (sys_rst_i)
			$past(s_r.ph && !s_r.ov && !s_r.oc) |-> red_led_o == (!s_r.slot[0] && s_r.slot < 4'h8);
	endproperty
	a_phb: assert property (p_phb) else $error("ph blinks wrong");
	property p_ocb;
		@(posedge mclk_i) disable iff (sys_rst_i) $past(s_r.oc) && s_r.slot >= 4'h2 |-> !red_led_o;
	endproperty
	a_ocb: assert property (p_ocb) else $error("oc extra blink");
	property p_tail;
		@(posedge mclk_i) disable iff (sys_rst_i) s_r.slot >= 4'h8 |-> !red_led_o;
	endproperty
	a_tail: assert property (p_tail) else $error("red on in tail");
	property p_query;
		@(posedge mclk_i) disable iff (sys_rst_i)
			rx_stb && rx_data == sfi_pkg::CMD_STATUS && !tx_busy |=> s_r.tstb ##1 tx_busy;
	endproperty
	a_query: assert property (p_query) else $error("query not answered");
endmodule : sfi_fault_ind
`default_nettype wire

// *** inc/sfi_pkg.sv ***
`default_nettype none
package sfi_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned PERIOD_MS     = 3000;           // Indication period
	localparam int unsigned BLINK_MS      = 250;            // One on or off interval
	localparam int unsigned PERIOD_CYC    = CLK_HZ / 1000 * PERIOD_MS;
	localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned BAUD          = 38400;
	localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;  // Longest time rounds down
	// ------------------------------------------------------------
	// Blink counts per fault
	// ------------------------------------------------------------
	localparam logic [2:0] BLINKS_OC      = 3'h1;
	localparam logic [2:0] BLINKS_OV      = 3'h2;
	localparam logic [2:0] BLINKS_PH      = 3'h4;
	// ------------------------------------------------------------
	// Serial status protocol
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_STATUS     = 8'h3f;          // Fault status query byte
	localparam logic [7:0] ANS_BASE       = 8'h30;          // Answer is base or fault bits
	localparam logic [2:0] FAULT_RST      = 3'h0;
	typedef enum logic [1:0] {SFI_NONE, SFI_OC, SFI_OV, SFI_PH} sfi_fault_t;
endpackage : sfi_pkg
`default_nettype wire

// *** logic/sfi_uart.sv ***
`default_nettype none
// Minimal 8N1 serial port; rx sampled mid-bit, tx one byte at a time
module sfi_uart #(
	parameter int unsigned BIT_CYC = sfi_pkg::BIT_CYC
) (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       rxd_i,
	output var  logic [7:0] rx_data_o,
	output var  logic       rx_stb_o,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_stb_i,
	output var  logic       txd_o,
	output var  logic       tx_busy_o
);
	typedef struct packed {
		logic [15:0] rcnt;
		logic [3:0]  rbit;
		logic [8:0]  rsh;
		logic        ract;
		logic [7:0]  rdat;
		logic        rstb;
		logic [15:0] tcnt;
		logic [3:0]  tbit;
		logic [9:0]  tsh;
		logic        tact;
	} sfi_uart_st_t;
	sfi_uart_st_t s_r, s_nxt;
	localparam logic [15:0] BC = 16'(BIT_CYC - 1);
	localparam logic [15:0] HC = 16'(BIT_CYC / 2);

	// ------------------------------------------------------------
	// Receiver and transmitter
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rstb = 1'b0;
		if (!s_r.ract)
		begin
			if (!rxd_i)
			begin
				s_nxt.ract = 1'b1;
				s_nxt.rcnt = HC;   // First sample lands mid start bit
				s_nxt.rbit = 4'h0;
			end
		end
		else if (s_r.rcnt != 16'h0)
			s_nxt.rcnt = s_r.rcnt - 16'h1;
		else
		begin
			s_nxt.rcnt = BC;
			s_nxt.rsh = {rxd_i, s_r.rsh[8:1]};
			s_nxt.rbit = s_r.rbit + 4'h1;
			if (s_r.rbit == 4'h0 && rxd_i)
				s_nxt.ract = 1'b0;   // False start, glitch
			else if (s_r.rbit == 4'h9)
			begin
				s_nxt.ract = 1'b0;
				s_nxt.rdat = s_r.rsh[8:1];
				s_nxt.rstb = rxd_i;  // Only framed bytes count
			end
		end
		if (!s_r.tact)
		begin
			if (tx_stb_i)
			begin
				s_nxt.tact = 1'b1;
				s_nxt.tsh = {1'b1, tx_data_i, 1'b0};
				s_nxt.tcnt = BC;
				s_nxt.tbit = 4'h0;
			end
		end
		else if (s_r.tcnt != 16'h0)
			s_nxt.tcnt = s_r.tcnt - 16'h1;
		else
		begin
			s_nxt.tcnt = BC;
			s_nxt.tsh = {1'b1, s_r.tsh[9:1]};
			s_nxt.tbit = s_r.tbit + 4'h1;
			if (s_r.tbit == 4'h9)
				s_nxt.tact = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_r <= '0;
			s_r.tsh <= 10'h3ff;
		end
		else
			s_r <= s_nxt;
	end

	assign rx_data_o = s_r.rdat;
	assign rx_stb_o = s_r.rstb;
	assign txd_o = s_r.tact ? s_r.tsh[0] : 1'b1;
	assign tx_busy_o = s_r.tact;
endmodule : sfi_uart
`default_nettype wire

// *** test/sfi_host_model.sv ***
`default_nettype none
// Host tuning tool on the serial link
module sfi_host_model #(
	parameter int BIT_CYC = 8
) (
	input  wire logic mclk_i,
	input  wire logic txd_i,
	output var  logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd_o = 1'b1;
	// ------------------------------------------------------------
	// Query and reply
	// ------------------------------------------------------------
	// Stop bit is cut short so a prompt reply start is never missed
	task automatic query(input logic [7:0] q, output logic [7:0] ans, output logic got);
		logic [8:0] frm;
		int         n;
		frm = {q, 1'b0};
		got = 1'b0;
		ans = 8'h00;
		for (int i = 0; i < 9; i++)
		begin
			@(posedge mclk_i);
			rxd_o <= frm[i];
			repeat (BIT_CYC - 1) @(posedge mclk_i);
		end
		@(posedge mclk_i);
		rxd_o <= 1'b1;
		n = 0;
		// Watch off the edge, where the reply start is settled
		while (txd_i !== 1'b0 && n < 20 * BIT_CYC)
		begin
			@(negedge mclk_i);
			n++;
		end
		if (txd_i !== 1'b0)
			return;
		repeat (BIT_CYC / 2) @(posedge mclk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge mclk_i);
			ans[i] = txd_i; // LSB first
		end
		repeat (BIT_CYC) @(posedge mclk_i);
		got = (txd_i === 1'b1);
	endtask : query
endmodule : sfi_host_model
`default_nettype wire

// *** test/sfi_fault_ind_tb.sv ***
`default_nettype none
module sfi_fault_ind_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 200;
	localparam int BLK = 10;
	localparam int BITC = 8;
	logic mclk_i      = 1'b0;
	logic sys_rst_i   = 1'b1;
	logic ovolt_det_i = 1'b0;
	logic phase_err_i = 1'b0;
	logic ocur_det_i  = 1'b0;
	logic rxd;
	logic txd;
	logic drive_en;
	logic ready;
	logic red;
	logic green;
	int   fails       = 0;
	int   checks      = 0;
	// 40 MHz clock
	always #12.5 mclk_i = ~mclk_i;
	sfi_fault_ind #(.PERIOD_CYC(PER), .BLINK_CYC(BLK), .BIT_CYC(BITC)) u_sfi_fault_ind (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ovolt_det_i(ovolt_det_i), .phase_err_i(phase_err_i),
		.ocur_det_i(ocur_det_i), .rxd_i(rxd), .txd_o(txd), .drive_en_o(drive_en), .ready_o(ready),
		.red_led_o(red), .green_led_o(green));
	sfi_host_model #(.BIT_CYC(BITC)) u_sfi_host_model (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	// Power cycle is the only way out of a latched fault
	task automatic power_cycle;
		@(posedge mclk_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : power_cycle
	// Single-cycle detector pulse; inputs drop before checking
	task automatic pulse_faults(input logic ov, input logic ph, input logic oc);
		@(posedge mclk_i);
		{ovolt_det_i, phase_err_i, ocur_det_i} <= {ov, ph, oc};
		@(posedge mclk_i);
		{ovolt_det_i, phase_err_i, ocur_det_i} <= 3'h0;
		repeat (3) @(posedge mclk_i);
	endtask : pulse_faults
	// One full period window holds each pulse edge exactly once
	task automatic check_fault(input string name, input int n, input logic [7:0] reply);
		int         edges;
		int         on;
		logic       prev;
		logic [7:0] ans;
		logic       got;
		edges = 0;
		on = 0;
		// Baseline taken off the edge so a pulse starting now still counts
		@(negedge mclk_i);
		prev = red;
		chk("drive_en", 8'h00, {7'h0, drive_en});
		chk("ready", 8'h00, {7'h0, ready});
		chk("green", 8'h01, {7'h0, green});
		repeat (PER)
		begin
			@(negedge mclk_i);
			edges += (red === 1'b1 && prev !== 1'b1);
			on += (red === 1'b1);
			prev = red;
		end
		chk({name, " blinks"}, n[7:0], edges[7:0]);
		chk({name, " on cycles"}, n[7:0] * BLK[7:0], on[7:0]);
		u_sfi_host_model.query(sfi_pkg::CMD_STATUS, ans, got);
		chk({name, " reply"}, reply, ans);
		chk({name, " framed"}, 8'h01, {7'h0, got});
	endtask : check_fault
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_power_up;
		logic [7:0] ans;
		logic       got;
		chk("green", 8'h01, {7'h0, green});
		chk("drive_en", 8'h01, {7'h0, drive_en});
		chk("ready", 8'h01, {7'h0, ready});
		chk("red", 8'h00, {7'h0, red});
		u_sfi_host_model.query(8'h55, ans, got);
		chk("foreign byte answered", 8'h00, {7'h0, got});
		u_sfi_host_model.query(sfi_pkg::CMD_STATUS, ans, got);
		chk("idle reply", sfi_pkg::ANS_BASE, ans);
		$display("power up done");
	endtask : t_power_up
	task automatic t_over_voltage;
		power_cycle();
		pulse_faults(1'b1, 1'b0, 1'b0);
		check_fault("ov", 2, 8'h32);
		$display("over-voltage done");
	endtask : t_over_voltage
	task automatic t_phase_error;
		power_cycle();
		pulse_faults(1'b0, 1'b1, 1'b0);
		check_fault("ph", 4, 8'h34);
		$display("phase error done");
	endtask : t_phase_error
	task automatic t_priority;
		power_cycle();
		pulse_faults(1'b1, 1'b1, 1'b0);
		check_fault("ov+ph", 2, 8'h36);
		pulse_faults(1'b0, 1'b0, 1'b1);
		check_fault("all", 1, 8'h37);
		power_cycle();
		chk("cleared", 8'h01, {7'h0, drive_en});
		$display("priority done");
	endtask : t_priority
	initial
	begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		t_power_up();
		t_over_voltage();
		t_phase_error();
		t_priority();
		complete_run();
	end
endmodule : sfi_fault_ind_tb
`default_nettype wire
